// [rtl/ccrd_top.sv]
// Clock ratio decoder: captures the reset configuration straps once and
// drives the core PLL and system PLL settings from registers.
// Assumes strap pins are asynchronous levels held stable around reset release
// and a plain register port on mclk with one-cycle read latency.
`timescale 1ns/1ps
`include "ccrd_map.svh"

module ccrd_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,

	// Reset configuration straps
	input wire logic [`CCRD_CORE_W-1:0] core_ratio_pin,
	input wire logic [`CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W-1:0] system_pll_multiplier_field_pin,

	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,

	// PLL settings
	output ccrd_pkg::ccrd_core_cfg_t core_cfg,
	output ccrd_pkg::ccrd_csb_cfg_t csb_cfg,
	output logic core_pll_en,
	output logic csb_pll_en,
	output logic cfg_locked
);

	localparam ccrd_pkg::ccrd_core_cfg_t CORE_RST = '{
		bypass: 1'b1,
		mult_x2: `CCRD_X2_1P0,
		vco_div: ccrd_pkg::CCRD_VCO_DIV2,
		reserved: 1'b0
	};

	localparam ccrd_pkg::ccrd_csb_cfg_t CSB_RST = '{
		mult: `CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_MIN,
		reserved: 1'b0
	};

	// Synchronised straps
	logic [`CCRD_CORE_W-1:0] core_sync;
	logic [`CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W-1:0] system_pll_multiplier_field_sync;

	// Captured raw fields
	logic [`CCRD_CORE_W-1:0] core_raw_r;
	logic [`CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W-1:0] system_pll_multiplier_field_raw_r;

	// Decoded from the synchronised straps
	ccrd_pkg::ccrd_core_cfg_t core_dec;
	ccrd_pkg::ccrd_csb_cfg_t csb_dec;

	// Output flops
	ccrd_pkg::ccrd_core_cfg_t core_cfg_r;
	ccrd_pkg::ccrd_csb_cfg_t csb_cfg_r;
	logic core_pll_en_r;
	logic csb_pll_en_r;
	logic cfg_locked_r;
	logic [31:0] reg_rdata_r;

	// Capture sequencer
	ccrd_pkg::ccrd_state_t state_r;
	ccrd_pkg::ccrd_state_t state_nxt;
	logic [1:0] settle_r;
	logic capture;
	logic settle_done;

	// Control register
	logic ctrl_en_r;

	// Register decode and read words
	logic [2:0] addr_hit;
	logic ctrl_wr;
	logic [31:0] status_w;
	logic [31:0] raw_w;
	logic [31:0] ctrl_w;
	logic [31:0] rd_mux;

	ccrd_sync2 #(
		.W(`CCRD_CORE_W)
	) u_sync_core (
		.mclk(mclk),
		.rstn(rstn),
		.d(core_ratio_pin),
		.q(core_sync)
	);

	ccrd_sync2 #(
		.W(`CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W)
	) u_sync_system_pll_multiplier_field (
		.mclk(mclk),
		.rstn(rstn),
		.d(system_pll_multiplier_field_pin),
		.q(system_pll_multiplier_field_sync)
	);

	ccrd_decode u_decode (
		.core_ratio_field(core_sync),
		.system_pll_multiplier_field(system_pll_multiplier_field_sync),
		.core_cfg(core_dec),
		.csb_cfg(csb_dec)
	);

	// Strap values only reach the synchroniser output after its stages fill,
	// so the capture waits a fixed count of edges after release.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ccrd_pkg::CCRD_ST_WAIT: begin
				state_nxt = ccrd_pkg::CCRD_ST_SETTLE;
			end
			ccrd_pkg::CCRD_ST_SETTLE: begin
				if (settle_r == `CCRD_SETTLE_CYC) begin
					state_nxt = ccrd_pkg::CCRD_ST_LOCKED;
				end
			end
			ccrd_pkg::CCRD_ST_LOCKED: begin
				state_nxt = ccrd_pkg::CCRD_ST_LOCKED;
			end
			default: begin
				state_nxt = ccrd_pkg::CCRD_ST_WAIT;
			end
		endcase
	end

	// Last settle edge; the synchroniser has long filled by then
	assign settle_done = (settle_r == `CCRD_SETTLE_CYC);
	assign capture = (state_r == ccrd_pkg::CCRD_ST_SETTLE) && settle_done;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ccrd_pkg::CCRD_ST_WAIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			settle_r <= 2'h0;
		end else if (state_r == ccrd_pkg::CCRD_ST_SETTLE && !capture) begin
			settle_r <= settle_r + 2'h1;
		end
	end

	// Fields are taken once; no later strap change reaches the PLLs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			core_raw_r <= '0;
		end else if (capture) begin
			core_raw_r <= core_sync;
		end
	end

	// Taken beside the core field on the same edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			system_pll_multiplier_field_raw_r <= '0;
		end else if (capture) begin
			system_pll_multiplier_field_raw_r <= system_pll_multiplier_field_sync;
		end
	end

	// Reserved codes arrive here already folded to safe settings
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			core_cfg_r <= CORE_RST;
		end else if (capture) begin
			core_cfg_r <= core_dec;
		end
	end

	// A reserved multiplier is kept as is so software can see it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			csb_cfg_r <= CSB_RST;
		end else if (capture) begin
			csb_cfg_r <= csb_dec;
		end
	end

	// Locked only rises; a new reset is the one way back
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_locked_r <= 1'b0;
		end else if (capture) begin
			cfg_locked_r <= 1'b1;
		end
	end

	// Offset decode shared by the write and read paths
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		reg_sel = 3'h0;
		unique case (a)
			`CCRD_OFF_STATUS: begin
				reg_sel = 3'h1;
			end
			`CCRD_OFF_RAW: begin
				reg_sel = 3'h2;
			end
			`CCRD_OFF_CTRL: begin
				reg_sel = 3'h4;
			end
			default: begin
				reg_sel = 3'h0;
			end
		endcase
	endfunction

	// Writes to read-only offsets fall through harmlessly
	assign addr_hit = reg_sel(reg_addr);
	assign ctrl_wr = reg_wr && addr_hit[2];

	// Software may hold the PLLs off, but cannot change their ratios
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_en_r <= `CCRD_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_en_r <= reg_wdata[`CCRD_CTRL_EN];
		end
	end

	// Bypass turns the core PLL off; the core runs straight from the bus clock
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			core_pll_en_r <= 1'b0;
		end else begin
			core_pll_en_r <= cfg_locked_r && ctrl_en_r && !core_cfg_r.bypass;
		end
	end

	// A reserved bus multiplier keeps the system PLL idle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			csb_pll_en_r <= 1'b0;
		end else begin
			csb_pll_en_r <= cfg_locked_r && ctrl_en_r && !csb_cfg_r.reserved;
		end
	end

	// Status mirrors the captured settings, never the live straps
	always_comb begin
		status_w = 32'h0;
		status_w[`CCRD_ST_LOCKED] = cfg_locked_r;
		status_w[`CCRD_ST_BYPASS] = core_cfg_r.bypass;
		status_w[`CCRD_ST_X2_LSB +: 4] = core_cfg_r.mult_x2;
		status_w[`CCRD_ST_VCO_LSB +: 2] = core_cfg_r.vco_div;
		status_w[`CCRD_ST_CRES] = core_cfg_r.reserved;
		status_w[`CCRD_ST_MULT_LSB +: 4] = csb_cfg_r.mult;
		status_w[`CCRD_ST_SRES] = csb_cfg_r.reserved;
	end

	// Raw fields show a reserved code even after it was folded
	always_comb begin
		raw_w = 32'h0;
		raw_w[`CCRD_CORE_W-1:0] = core_raw_r;
		raw_w[`CCRD_RAW_SYSTEM_PLL_MULTIPLIER_FIELD_LSB +: `CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W] = system_pll_multiplier_field_raw_r;
	end

	// Only the enable bit is writable
	always_comb begin
		ctrl_w = 32'h0;
		ctrl_w[`CCRD_CTRL_EN] = ctrl_en_r;
	end

	// Unmapped offsets read as zero
	always_comb begin
		rd_mux = 32'h0;
		if (addr_hit[0]) begin
			rd_mux = status_w;
		end
		if (addr_hit[1]) begin
			rd_mux = raw_w;
		end
		if (addr_hit[2]) begin
			rd_mux = ctrl_w;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_mux;
		end else begin
			reg_rdata_r <= 32'h0;
		end
	end

	// Outputs are plain copies of the flops
	assign reg_rdata = reg_rdata_r;
	assign core_cfg = core_cfg_r;
	assign csb_cfg = csb_cfg_r;
	assign core_pll_en = core_pll_en_r;
	assign csb_pll_en = csb_pll_en_r;
	assign cfg_locked = cfg_locked_r;

endmodule

// [rtl/ccrd_map.svh]
// Offsets, field positions, reset values and timing counts of the clock ratio decoder.
// Assumes a byte-addressed plain register port with 8-bit addresses and 32-bit data.
`ifndef CCRD_MAP_SVH
`define CCRD_MAP_SVH

// Register offsets
`define CCRD_OFF_STATUS 8'h00
`define CCRD_OFF_RAW 8'h04
`define CCRD_OFF_CTRL 8'h08

// Core ratio field layout, bit 0 of the field is the VCO divider LSB
`define CCRD_CORE_W 7
`define CCRD_VCO_LSB 0
`define CCRD_VCO_MSB 1
`define CCRD_RATIO_LSB 2
`define CCRD_RATIO_MSB 5
`define CCRD_HALF_BIT 6
`define CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W 4

// Core ratio codes and ratios in half steps
`define CCRD_RATIO_OFF 4'h0
`define CCRD_RATIO_1 4'h1
`define CCRD_RATIO_2 4'h2
`define CCRD_RATIO_3 4'h3
`define CCRD_X2_1P0 4'h2
`define CCRD_X2_1P5 4'h3
`define CCRD_X2_2P0 4'h4
`define CCRD_X2_2P5 4'h5
`define CCRD_X2_3P0 4'h6

// System PLL multiplier range
`define CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_MIN 4'h2
`define CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_MAX 4'h6

// Status register fields
`define CCRD_ST_LOCKED 0
`define CCRD_ST_BYPASS 1
`define CCRD_ST_X2_LSB 2
`define CCRD_ST_VCO_LSB 6
`define CCRD_ST_CRES 8
`define CCRD_ST_MULT_LSB 9
`define CCRD_ST_SRES 13
`define CCRD_RAW_SYSTEM_PLL_MULTIPLIER_FIELD_LSB 8
`define CCRD_CTRL_EN 0

// Reset values
`define CCRD_CTRL_RST 1'b1

// Timing: synchroniser depth and the settle count at which the straps are captured
`define CCRD_SYNC_STAGES 2
`define CCRD_SETTLE_CYC 2'h3

`endif

// [rtl/ccrd_pkg.sv]
// Types shared by the clock ratio decoder files.
// Assumes ccrd_map.svh supplies the numeric constants.
package ccrd_pkg;

	typedef enum logic [1:0] {
		CCRD_VCO_DIV2 = 2'b00,
		CCRD_VCO_DIV4 = 2'b01,
		CCRD_VCO_DIV8 = 2'b10
	} ccrd_vco_t;

	typedef enum logic [1:0] {
		CCRD_ST_WAIT = 2'b00,
		CCRD_ST_SETTLE = 2'b01,
		CCRD_ST_LOCKED = 2'b10
	} ccrd_state_t;

	typedef struct packed {
		logic bypass;
		logic [3:0] mult_x2;
		ccrd_vco_t vco_div;
		logic reserved;
	} ccrd_core_cfg_t;

	typedef struct packed {
		logic [3:0] mult;
		logic reserved;
	} ccrd_csb_cfg_t;

endpackage

// [rtl/ccrd_sync2.sv]
// Two-flop synchroniser for a bundle of independent strap levels.
// Assumes each bit is a slow level; no word coherence is implied.
`timescale 1ns/1ps
`include "ccrd_map.svh"

module ccrd_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					meta_r[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_r[i] <= d[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule

// [rtl/ccrd_decode.sv]
// Combinational decode of the core ratio and system multiplier fields.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`include "ccrd_map.svh"

module ccrd_decode (
	// Fields
	input wire logic [`CCRD_CORE_W-1:0] core_ratio_field,
	input wire logic [`CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_W-1:0] system_pll_multiplier_field,
	// Decoded
	output ccrd_pkg::ccrd_core_cfg_t core_cfg,
	output ccrd_pkg::ccrd_csb_cfg_t csb_cfg
);

	function automatic ccrd_pkg::ccrd_vco_t vco_sel(input logic [1:0] b);
		unique case (b)
			2'b00: vco_sel = ccrd_pkg::CCRD_VCO_DIV2;
			2'b01: vco_sel = ccrd_pkg::CCRD_VCO_DIV4;
			default: vco_sel = ccrd_pkg::CCRD_VCO_DIV8;
		endcase
	endfunction

	logic [3:0] ratio;
	logic half;

	assign ratio = core_ratio_field[`CCRD_RATIO_MSB:`CCRD_RATIO_LSB];
	assign half = core_ratio_field[`CCRD_HALF_BIT];

	always_comb begin
		core_cfg.bypass = 1'b0;
		core_cfg.mult_x2 = `CCRD_X2_1P0;
		core_cfg.vco_div = vco_sel(core_ratio_field[`CCRD_VCO_MSB:`CCRD_VCO_LSB]);
		core_cfg.reserved = 1'b0;
		if (ratio == `CCRD_RATIO_OFF) begin
			core_cfg.bypass = 1'b1;
			core_cfg.vco_div = ccrd_pkg::CCRD_VCO_DIV2;
		end else begin
			unique case ({ratio, half})
				{`CCRD_RATIO_1, 1'b0}: core_cfg.mult_x2 = `CCRD_X2_1P0;
				{`CCRD_RATIO_1, 1'b1}: core_cfg.mult_x2 = `CCRD_X2_1P5;
				{`CCRD_RATIO_2, 1'b0}: core_cfg.mult_x2 = `CCRD_X2_2P0;
				{`CCRD_RATIO_2, 1'b1}: core_cfg.mult_x2 = `CCRD_X2_2P5;
				{`CCRD_RATIO_3, 1'b0}: core_cfg.mult_x2 = `CCRD_X2_3P0;
				default: begin
					// Reserved codes fall back to bypass, the one setting always safe
					core_cfg.bypass = 1'b1;
					core_cfg.vco_div = ccrd_pkg::CCRD_VCO_DIV2;
					core_cfg.reserved = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		csb_cfg.mult = system_pll_multiplier_field;
		csb_cfg.reserved = (system_pll_multiplier_field < `CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_MIN) ||
			(system_pll_multiplier_field > `CCRD_SYSTEM_PLL_MULTIPLIER_FIELD_MAX);
	end

endmodule

// [verif/ccrd_top_checker.sv]
// Port checker for the clock ratio decoder top.
// Assumes straps held steady from reset release until capture.
`timescale 1ns/1ps
module ccrd_top_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Straps
	input wire logic [6:0] core_ratio_pin,
	input wire logic [3:0] system_pll_multiplier_field_pin,
	// Settings
	input ccrd_pkg::ccrd_core_cfg_t core_cfg,
	input ccrd_pkg::ccrd_csb_cfg_t csb_cfg,
	input wire logic core_pll_en,
	input wire logic cfg_locked
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_cap;
		$rose(cfg_locked);
	endsequence
	sequence s_run;
		s_cap ##0 !core_cfg.bypass;
	endsequence
	property p_ratio;
		s_run |-> core_cfg.mult_x2 == {core_ratio_pin[4:2], core_ratio_pin[6]};
	endproperty
	a_ratio: assert property (p_ratio) else $error("core ratio");
	property p_vco;
		s_run |-> core_cfg.vco_div == (core_ratio_pin[1] ? 2'h2 : {1'b0, core_ratio_pin[0]});
	endproperty
	a_vco: assert property (p_vco) else $error("vco divider");
	property p_off;
		s_cap ##0 core_ratio_pin[5:2] == 4'h0 |-> core_cfg.bypass && !core_cfg.reserved;
	endproperty
	a_off: assert property (p_off) else $error("bypass");
	property p_csb;
		s_cap ##0 system_pll_multiplier_field_pin inside {[4'h2:4'h6]} |-> csb_cfg.mult == system_pll_multiplier_field_pin && !csb_cfg.reserved;
	endproperty
	a_csb: assert property (p_csb) else $error("bus ratio");
	property p_en;
		s_cap |=> core_pll_en == !core_cfg.bypass;
	endproperty
	a_en: assert property (p_en) else $error("core pll enable");
	property p_lat;
		$rose(rstn) |-> !cfg_locked [*5] ##1 cfg_locked;
	endproperty
	a_lat: assert property (p_lat) else $error("capture time");
	property p_hold;
		cfg_locked |=> $stable(core_cfg) && $stable(csb_cfg);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved");
endmodule

bind ccrd_top ccrd_top_checker u_chk (.mclk(mclk), .rstn(rstn),
	.core_ratio_pin(core_ratio_pin), .system_pll_multiplier_field_pin(system_pll_multiplier_field_pin), .core_cfg(core_cfg),
	.csb_cfg(csb_cfg), .core_pll_en(core_pll_en), .cfg_locked(cfg_locked));

// [verif/ccrd_top_tb_top.sv]
// Bench for the clock ratio decoder: strap rows, then registers.
// Assumes straps change only while reset is held, apart from the post-capture hold test.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module ccrd_top_tb_top;
	logic mclk, rstn, reg_wr, reg_rd, core_pll_en, csb_pll_en, cfg_locked;
	logic [6:0] core_ratio_pin;
	logic [3:0] system_pll_multiplier_field_pin;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	ccrd_pkg::ccrd_core_cfg_t core_cfg;
	ccrd_pkg::ccrd_csb_cfg_t csb_cfg;
	int fails, n_compared, cyc;
	// Core strap, multiplier strap, expected core settings, multiplier reserved
	localparam logic [19:0] ROWS [10] = '{{7'h04, 4'h2, 8'h10, 1'b0},
		{7'h45, 4'h3, 8'h1A, 1'b0}, {7'h0A, 4'h4, 8'h24, 1'b0}, {7'h4B, 4'h5, 8'h2C, 1'b0},
		{7'h0C, 4'h6, 8'h30, 1'b0}, {7'h43, 4'h0, 8'h90, 1'b1}, {7'h49, 4'h1, 8'h2A, 1'b1},
		{7'h07, 4'h7, 8'h14, 1'b1}, {7'h0D, 4'hF, 8'h32, 1'b1}, {7'h00, 4'h6, 8'h90, 1'b0}};
	ccrd_top dut (.mclk(mclk), .rstn(rstn), .core_ratio_pin(core_ratio_pin),
		.system_pll_multiplier_field_pin(system_pll_multiplier_field_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_cfg(core_cfg), .csb_cfg(csb_cfg),
		.core_pll_en(core_pll_en), .csb_pll_en(csb_pll_en), .cfg_locked(cfg_locked));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Whole run is under a few hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			conclude();
		end
	end
	task automatic boot(input logic [6:0] c, input logic [3:0] s);
		@(posedge mclk);
		rstn <= 1'b0;
		core_ratio_pin <= c;
		system_pll_multiplier_field_pin <= s;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (10) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata)
		@(posedge mclk);
		#1;
		`CHK("rdata idle", 32'h0, reg_rdata)
	endtask
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		core_ratio_pin = 7'h04;
		system_pll_multiplier_field_pin = 4'h2;
		{fails, n_compared, cyc} = '0;
		repeat (16) @(posedge mclk);
		#1;
		`CHK("rst core", 8'h90, core_cfg)
		`CHK("rst flags", 3'h0, {core_pll_en, csb_pll_en, cfg_locked})
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			boot(ROWS[i][19:13], ROWS[i][12:9]);
			`CHK("core", ROWS[i][8:1], core_cfg)
			`CHK("bus res", ROWS[i][0], csb_cfg.reserved)
			if (!ROWS[i][0])
				`CHK("bus mult", ROWS[i][12:9], csb_cfg.mult)
			`CHK("flags", {~ROWS[i][8], ~ROWS[i][0], 1'b1}, {core_pll_en, csb_pll_en, cfg_locked})
			$display("row %0d done", i);
		end
		boot(7'h4B, 4'h5);
		@(posedge mclk);
		core_ratio_pin <= 7'h7E;
		system_pll_multiplier_field_pin <= 4'hF;
		repeat (8) @(posedge mclk);
		#1;
		`CHK("held", 13'h058A, {core_cfg, csb_cfg})
		rd(8'h00, 32'h0000_0A95);
		rd(8'h04, 32'h0000_054B);
		wr(8'h00, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0000_0A95);
		rd(8'h08, 32'h0000_0001);
		rd(8'h40, 32'h0000_0000);
		wr(8'h08, 32'h0000_0000);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("pll off", 2'h0, {core_pll_en, csb_pll_en})
		rd(8'h08, 32'h0000_0000);
		$display("register test done");
		conclude();
	end
endmodule
